// ---- awc_regs.svh ----
/*
  Constants and behaviour summary for the converter window comparator.
  Assumes an 8-bit special-function register port from the CPU core.
*/
// Behaviour
// R1 - Writable upper byte of less-than limit
// R2 - Compare at each end of conversion, set flag
// R3 - Lower above upper: flag when strictly inside
// R4 - Lower below upper: flag when strictly outside
// R5 - Conversion takes at least sixteen converter clocks
// R6 - Hardware only sets flag; software clears it
// R7 - Both limits held as separate high, low bytes
// R8 - Every conversion result compared against limits
// R9 - Differential signed, single-ended unsigned comparison
`ifndef AWC_REGS_SVH
`define AWC_REGS_SVH
`define AWC_ADDR_UPPER_HIGH 8'hc4
`define AWC_ADDR_UPPER_LOW 8'hc5
`define AWC_ADDR_LOWER_LOW 8'hc6
`define AWC_ADDR_LOWER_HIGH 8'hc7
`define AWC_ADDR_CONTROL 8'he8
`define AWC_LIMIT_RESET 8'h00
`define AWC_UPPER_RESET 8'hff
`define AWC_CTRL_RESET 8'h00
`define AWC_FLAG_RESET 1'b0
`define AWC_LJUST_RESET 1'b0
`define AWC_WORD_RESET 16'h0000
`define AWC_CNT_RESET 5'd0
`define AWC_BIT_MATCH 1
`define AWC_BIT_LJUST 0
`define AWC_CONV_MIN_CLKS 5'd16
`endif

// ---- awc_pkg.sv ----
/*
  Types for the converter window comparator.
  Assumes nothing beyond the register header.
*/
package awc_pkg;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } awc_sfr_wr_t;
  typedef struct packed {
    logic eoc;
    logic diff;
    logic [9:0] code;
  } awc_conv_t;
endpackage

// ---- awc_compare.sv ----
/*
  Combinational window test on one presented 16-bit data word.
  Assumes limits and data share the same justification and sign format.
*/
`timescale 1ns/1ps
module awc_compare
(
  input wire logic [15:0] i_data,
  input wire logic [15:0] i_lower,
  input wire logic [15:0] i_upper,
  input wire logic i_signed,
  output logic o_hit
);
  logic below;
  logic above;
  // Flip the sign bit so one unsigned compare serves both formats
  always_comb
  begin
    below = ({i_data[15] ^ i_signed, i_data[14:0]} <
             {i_lower[15] ^ i_signed, i_lower[14:0]}); // see R9
    above = ({i_data[15] ^ i_signed, i_data[14:0]} >
             {i_upper[15] ^ i_signed, i_upper[14:0]}); // see R9
    if ({i_lower[15] ^ i_signed, i_lower[14:0]} > {i_upper[15] ^ i_signed, i_upper[14:0]})
    begin
      o_hit = below && above; // see R3
    end
    else
    begin
      o_hit = below || above; // see R4
    end
  end
endmodule // awc_compare

// ---- awc_window_top.sv ----
/*
  Window comparator: limit registers, data formatting, sticky match flag.
  Assumes the converter core pulses end of conversion for one system
  clock and holds the 10-bit code and the differential indication then.
*/
`timescale 1ns/1ps
`include "awc_regs.svh"
module awc_window_top
(
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_SFR_WR,
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic [7:0] I_SFR_WDATA,
  input wire logic [7:0] I_SFR_RADDR,
  input wire logic I_EOC,
  input wire logic I_DIFF,
  input wire logic [9:0] I_CODE,
  input wire logic I_SAR_TICK,
  output logic [7:0] O_SFR_RDATA,
  output logic [15:0] O_DATA_WORD,
  output logic O_WINDOW_MATCH_FLAG,
  output logic O_LEFT_JUSTIFY_SELECT
);
  awc_pkg::awc_sfr_wr_t bus;
  awc_pkg::awc_conv_t conv;
  logic [7:0] window_lower_limit_high_r, window_lower_limit_high_nxt;
  logic [7:0] window_lower_limit_low_r, window_lower_limit_low_nxt;
  logic [7:0] window_upper_limit_high_r, window_upper_limit_high_nxt;
  logic [7:0] window_upper_limit_low_r, window_upper_limit_low_nxt;
  logic flag_r, flag_nxt;
  logic ljust_r, ljust_nxt;
  logic [15:0] word;
  logic [15:0] word_r, word_nxt;
  logic [4:0] sar_cnt_r, sar_cnt_nxt;
  logic eoc_ok;
  logic hit;

  assign bus = '{wr: I_SFR_WR, addr: I_SFR_ADDR, wdata: I_SFR_WDATA};
  assign conv = '{eoc: I_EOC, diff: I_DIFF, code: I_CODE};

  // Limit bytes, each separately writable
  always_comb
  begin
    window_lower_limit_high_nxt = window_lower_limit_high_r;
    window_lower_limit_low_nxt = window_lower_limit_low_r;
    window_upper_limit_high_nxt = window_upper_limit_high_r;
    window_upper_limit_low_nxt = window_upper_limit_low_r;
    ljust_nxt = ljust_r;
    if (bus.wr)
    begin
      unique case (bus.addr)
        `AWC_ADDR_LOWER_HIGH: window_lower_limit_high_nxt = bus.wdata; // see R1
        `AWC_ADDR_LOWER_LOW: window_lower_limit_low_nxt = bus.wdata; // see R7
        `AWC_ADDR_UPPER_HIGH: window_upper_limit_high_nxt = bus.wdata; // see R7
        `AWC_ADDR_UPPER_LOW: window_upper_limit_low_nxt = bus.wdata; // see R7
        `AWC_ADDR_CONTROL: ljust_nxt = bus.wdata[`AWC_BIT_LJUST];
        default: ljust_nxt = ljust_r;
      endcase
    end
  end

  // Count SAR ticks since last result; early end-of-conversion ignored
  always_comb
  begin
    eoc_ok = conv.eoc && (sar_cnt_r >= `AWC_CONV_MIN_CLKS); // see R5
    sar_cnt_nxt = sar_cnt_r;
    if (conv.eoc)
    begin
      sar_cnt_nxt = `AWC_CNT_RESET; // see R5
    end
    else if (I_SAR_TICK && (sar_cnt_r < `AWC_CONV_MIN_CLKS))
    begin
      sar_cnt_nxt = sar_cnt_r + 5'd1;
    end
  end

  // Present the code as software would read it; hold it until the next accepted result
  always_comb
  begin
    word_nxt = word_r;
    if (ljust_r)
    begin
      word = {conv.code, 6'h00};
    end
    else
    begin
      word = {{6{conv.diff & conv.code[9]}}, conv.code}; // see R9
    end
    if (eoc_ok)
    begin
      word_nxt = word; // see R2
    end
  end

  awc_compare u_cmp
  (
    .i_data(word),
    .i_lower({window_lower_limit_high_r, window_lower_limit_low_r}),
    .i_upper({window_upper_limit_high_r, window_upper_limit_low_r}),
    .i_signed(conv.diff),
    .o_hit(hit)
  );

  // Sticky flag: set wins over a same-cycle software clear
  always_comb
  begin
    flag_nxt = flag_r;
    if (bus.wr && (bus.addr == `AWC_ADDR_CONTROL) && !bus.wdata[`AWC_BIT_MATCH])
    begin
      flag_nxt = 1'b0; // see R6
    end
    if (eoc_ok && hit)
    begin
      flag_nxt = 1'b1; // see R2 see R8
    end
  end

  // Limit and control bytes; reset leaves every limit at zero
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      window_lower_limit_high_r <= `AWC_LIMIT_RESET;
      window_lower_limit_low_r <= `AWC_LIMIT_RESET;
      window_upper_limit_high_r <= `AWC_LIMIT_RESET;
      window_upper_limit_low_r <= `AWC_LIMIT_RESET;
      ljust_r <= `AWC_LJUST_RESET;
    end
    else
    begin
      window_lower_limit_high_r <= window_lower_limit_high_nxt;
      window_lower_limit_low_r <= window_lower_limit_low_nxt;
      window_upper_limit_high_r <= window_upper_limit_high_nxt;
      window_upper_limit_low_r <= window_upper_limit_low_nxt;
      ljust_r <= ljust_nxt;
    end
  end

  // Conversion count and held data word
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      sar_cnt_r <= `AWC_CNT_RESET;
      word_r <= `AWC_WORD_RESET;
    end
    else
    begin
      sar_cnt_r <= sar_cnt_nxt;
      word_r <= word_nxt;
    end
  end

  // Sticky match flag
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      flag_r <= `AWC_FLAG_RESET;
    end
    else
    begin
      flag_r <= flag_nxt;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    unique case (I_SFR_RADDR)
      `AWC_ADDR_LOWER_HIGH: O_SFR_RDATA = window_lower_limit_high_r;
      `AWC_ADDR_LOWER_LOW: O_SFR_RDATA = window_lower_limit_low_r;
      `AWC_ADDR_UPPER_HIGH: O_SFR_RDATA = window_upper_limit_high_r;
      `AWC_ADDR_UPPER_LOW: O_SFR_RDATA = window_upper_limit_low_r;
      `AWC_ADDR_CONTROL: O_SFR_RDATA = {6'h00, flag_r, ljust_r};
      default: O_SFR_RDATA = 8'h00;
    endcase
  end

  assign O_DATA_WORD = word_r;
  assign O_WINDOW_MATCH_FLAG = flag_r;
  assign O_LEFT_JUSTIFY_SELECT = ljust_r;

  // Match flag: set by an accepted hit, dropped only by a software clear
  a_flag_set: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see R2 see R8
    (eoc_ok && hit) |=> O_WINDOW_MATCH_FLAG)
    else $error("match not flagged");
  a_flag_sticky: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see R6
    (O_WINDOW_MATCH_FLAG && !(I_SFR_WR && I_SFR_ADDR == `AWC_ADDR_CONTROL))
    |=> O_WINDOW_MATCH_FLAG)
    else $error("flag dropped without clear");
  a_flag_clear: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see R6
    (I_SFR_WR && I_SFR_ADDR == `AWC_ADDR_CONTROL && !I_SFR_WDATA[`AWC_BIT_MATCH]
    && !(eoc_ok && hit)) |=> !O_WINDOW_MATCH_FLAG)
    else $error("flag not cleared");
  a_flag_cause: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see R2
    $rose(O_WINDOW_MATCH_FLAG) |-> $past(eoc_ok && hit))
    else $error("flag set without match");
  // A rushed result must leave both word and flag alone
  a_early_eoc: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see R5
    (I_EOC && sar_cnt_r < `AWC_CONV_MIN_CLKS)
    |=> ($stable(O_DATA_WORD) && !$rose(O_WINDOW_MATCH_FLAG)))
    else $error("early result used");
  // Lower high and both upper limit bytes land one edge after their write
  a_lth_write: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see R1
    (I_SFR_WR && I_SFR_ADDR == `AWC_ADDR_LOWER_HIGH)
    |=> window_lower_limit_high_r == $past(I_SFR_WDATA))
    else $error("lower high not written");
  a_upper_low_write: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see R7
    (I_SFR_WR && I_SFR_ADDR == `AWC_ADDR_UPPER_LOW)
    |=> window_upper_limit_low_r == $past(I_SFR_WDATA))
    else $error("upper low not written");
  a_upper_high_write: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see R7
    (I_SFR_WR && I_SFR_ADDR == `AWC_ADDR_UPPER_HIGH)
    |=> window_upper_limit_high_r == $past(I_SFR_WDATA))
    else $error("upper high not written");
  // Fixed windows: plain right-justified data, then a signed window
  a_inside_hit: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see R3
    (!I_DIFF && !ljust_r && {window_lower_limit_high_r, window_lower_limit_low_r} == 16'h0200
    && {window_upper_limit_high_r, window_upper_limit_low_r} == 16'h0100)
    |-> hit == (I_CODE < 10'h200 && I_CODE > 10'h100))
    else $error("inside window wrong");
  a_outside_hit: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see R4
    (!I_DIFF && !ljust_r && {window_lower_limit_high_r, window_lower_limit_low_r} == 16'h0100
    && {window_upper_limit_high_r, window_upper_limit_low_r} == 16'h0200)
    |-> hit == (I_CODE > 10'h200 || I_CODE < 10'h100))
    else $error("outside window wrong");
  a_signed_neg: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see R9 see R8
    (I_DIFF && !ljust_r && I_CODE[9] && I_CODE != 10'h200
    && {window_lower_limit_high_r, window_lower_limit_low_r} == 16'h0000
    && {window_upper_limit_high_r, window_upper_limit_low_r} == 16'hfe00)
    |-> hit)
    else $error("signed compare wrong");
  // Main scenarios reached
  c_match: cover property (@(posedge I_CLK) disable iff (!I_RSTN) $rose(O_WINDOW_MATCH_FLAG));
  c_clear: cover property (@(posedge I_CLK) disable iff (!I_RSTN) $fell(O_WINDOW_MATCH_FLAG));
  c_diff_hit: cover property (@(posedge I_CLK) disable iff (!I_RSTN) eoc_ok && hit && I_DIFF);
  c_early: cover property (@(posedge I_CLK) disable iff (!I_RSTN) I_EOC && !eoc_ok);
endmodule // awc_window_top

// ---- awc_conv_model.sv ----
/* Converter core stand-in: SAR ticks, then one end-of-conversion pulse.
   Assumes one caller at a time. */
`timescale 1ns/1ps
module awc_conv_model
(
  input wire logic i_clk,
  output logic o_tick,
  output logic o_eoc,
  output logic o_diff,
  output logic [9:0] o_code
);
  // Idle outputs
  initial
  begin
    o_tick = 1'b0;
    o_eoc = 1'b0;
    o_diff = 1'b0;
    o_code = 10'h000;
  end
  // n below 16 models a rushed core, which must be ignored
  task automatic convert(input logic [9:0] c, input logic d, input int n);
    repeat (n)
    begin
      @(negedge i_clk) o_tick = 1'b1;
      @(negedge i_clk) o_tick = 1'b0;
    end
    @(negedge i_clk);
    o_eoc = 1'b1;
    o_code = c;
    o_diff = d;
    // Stale data inverted so it is never trusted
    @(negedge i_clk);
    o_eoc = 1'b0;
    o_code = ~c;
    o_diff = ~d;
  endtask
endmodule // awc_conv_model

// ---- adc_window_comparator_tb.sv ----
/* Bench for the window comparator, with a behavioural reference.
   Assumes one-cycle register writes and the core stand-in. */
`timescale 1ns/1ps
`include "awc_regs.svh"
module adc_window_comparator_tb;
  logic clk, rstn, wr, eoc, diff, tick, flag, lj, ef, elj, dsel;
  logic [7:0] addr, wdata, raddr, rdata;
  logic [9:0] code;
  logic [15:0] word, lo, up, ew;
  int mismatches, n_tests, seed, i;
  awc_window_top u_dut (.I_CLK(clk), .I_RSTN(rstn), .I_SFR_WR(wr), .I_SFR_ADDR(addr),
    .I_SFR_WDATA(wdata), .I_SFR_RADDR(raddr), .I_EOC(eoc), .I_DIFF(diff), .I_CODE(code),
    .I_SAR_TICK(tick), .O_SFR_RDATA(rdata), .O_DATA_WORD(word),
    .O_WINDOW_MATCH_FLAG(flag), .O_LEFT_JUSTIFY_SELECT(lj));
  awc_conv_model u_core (.i_clk(clk), .o_tick(tick), .o_eoc(eoc), .o_diff(diff),
    .o_code(code));
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e)
    begin
      mismatches++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    raddr = a;
    #1;
    chk("reg", {8'h00, rdata}, {8'h00, e});
  endtask
  // Reference word format and window test
  function automatic logic [15:0] fmt(logic [9:0] c, logic d, logic l);
    return l ? {c, 6'h00} : d ? {{6{c[9]}}, c} : {6'h00, c};
  endfunction
  function automatic logic hit(logic [15:0] w, logic s);
    int a, l, u;
    a = s ? int'($signed(w)) : int'(w);
    l = s ? int'($signed(lo)) : int'(lo);
    u = s ? int'($signed(up)) : int'(up);
    if (l > u)
      return a < l && a > u;
    return a > u || a < l;
  endfunction
  task automatic set_lim(input logic [15:0] l, input logic [15:0] u);
    lo = l;
    up = u;
    wr_reg(`AWC_ADDR_UPPER_HIGH, u[15:8]);
    wr_reg(`AWC_ADDR_UPPER_LOW, u[7:0]);
    wr_reg(`AWC_ADDR_LOWER_LOW, l[7:0]);
    wr_reg(`AWC_ADDR_LOWER_HIGH, l[15:8]);
    rd_chk(`AWC_ADDR_UPPER_HIGH, u[15:8]);
    rd_chk(`AWC_ADDR_UPPER_LOW, u[7:0]);
    rd_chk(`AWC_ADDR_LOWER_LOW, l[7:0]);
    rd_chk(`AWC_ADDR_LOWER_HIGH, l[15:8]);
  endtask
  // Clearing writes zero to the flag bit; the justify bit rides along
  task automatic clr(input logic l);
    wr_reg(`AWC_ADDR_CONTROL, {7'h00, l});
    elj = l;
    ef = 1'b0;
  endtask
  task automatic run(input logic [9:0] c, input logic d, input int n);
    u_core.convert(c, d, n);
    #1;
    if (n >= 16)
    begin
      ew = fmt(c, d, elj);
      ef = ef | hit(ew, d);
    end
    chk("word", word, ew);
    chk("flag", {15'h0000, flag}, {15'h0000, ef});
    chk("ljust", {15'h0000, lj}, {15'h0000, elj});
    rd_chk(`AWC_ADDR_CONTROL, {6'h00, ef, elj});
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    repeat (40000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
  // Main sequence: reset, fixed window cases, then random
  initial
  begin
    {wr, addr, wdata, raddr, ef, elj, ew, lo, up} = '0;
    seed = 32'hf051;
    rstn = 1'b0;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    rd_chk(`AWC_ADDR_LOWER_HIGH, 8'h00);
    wr_reg(`AWC_ADDR_LOWER_HIGH, 8'h5a);
    rd_chk(`AWC_ADDR_LOWER_HIGH, 8'h5a);
    rd_chk(8'h00, 8'h00);
    clr(1'b0);
    set_lim(16'h0200, 16'h0100);
    run(10'h180, 1'b0, 16);
    clr(1'b0);
    run(10'h100, 1'b0, 16);
    run(10'h180, 1'b0, 15);
    set_lim(16'h0100, 16'h0200);
    run(10'h250, 1'b0, 16);
    // Reset in mid-run: limits, flag and held word return to zero
    @(negedge clk);
    rstn = 1'b0;
    @(negedge clk);
    rstn = 1'b1;
    {ef, elj, ew, lo, up} = '0;
    rd_chk(`AWC_ADDR_LOWER_HIGH, 8'h00);
    rd_chk(`AWC_ADDR_CONTROL, 8'h00);
    chk("word", word, ew);
    // Signed window around the negative half
    set_lim(16'h0000, 16'hfe00);
    run(10'h3f0, 1'b1, 16);
    for (i = 0; i < 40; i++)
    begin
      if ($random(seed) % 3 == 0)
        clr($random(seed) & 1);
      dsel = $random(seed) & 1;
      set_lim(fmt($random(seed), dsel, elj), fmt($random(seed), dsel, elj));
      run($random(seed), dsel, ($random(seed) & 7) == 0 ? 15 : 16);
    end
    wrap_up();
  end
endmodule // adc_window_comparator_tb
